// ---- rtl/cam_interp.sv ----
`timescale 1ns/1ps
module cam_interp
   import cam_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire logic               go,
   input  wire logic [31:0]        y0,
   input  wire logic signed [32:0] dy,
   input  wire logic [31:0]        frac,
   input  wire logic [31:0]        len,
   output      logic               done,
   output      logic [31:0]        result
);
   typedef struct packed {
      logic        busy;
      logic [6:0]  cnt;
      logic [64:0] num;
      logic [32:0] rem;
      logic [31:0] len;
      logic [31:0] y0;
      logic        neg;
      logic        done;
      logic [31:0] result;
   } div_t;

   localparam logic [6:0] LAST_STEP = 7'h40;

   div_t r, n;
   logic [32:0] mag;
   logic [32:0] try_rem;
   logic [31:0] q;

   // bit-serial restoring divide: one quotient bit per clock, 65 clocks per point
   always_comb begin
      n = r;
      n.done = 1'b0;
      mag = dy[32] ? 33'(-dy) : 33'(dy);
      try_rem = {r.rem[31:0], r.num[64]};
      q = '0;
      if (go && !r.busy) begin
         n.busy = 1'b1;
         n.cnt = '0;
         n.num = {32'h0000_0000, mag} * {33'h0_0000_0000, frac};
         n.rem = '0;
         n.len = len;
         n.y0 = y0;
         n.neg = dy[32];
      end else if (r.busy) begin
         if (try_rem >= {1'b0, r.len}) begin
            n.rem = try_rem - {1'b0, r.len};
            n.num = {r.num[63:0], 1'b1};
         end else begin
            n.rem = try_rem;
            n.num = {r.num[63:0], 1'b0};
         end
         n.cnt = r.cnt + 7'h01;
         if (r.cnt == LAST_STEP) begin
            q = n.num[31:0];
            n.busy = 1'b0;
            n.done = 1'b1;
            n.result = r.neg ? r.y0 - q : r.y0 + q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign done = r.done;
   assign result = r.result;
endmodule : cam_interp

// ---- rtl/cam_pkg.sv ----
package cam_pkg;
   localparam int          DATA_W      = 32;
   localparam int          ADDR_W      = 8;
   localparam int          IDX_W       = 9;
   localparam int          TABLE_DEPTH = 257;
   // register byte addresses
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_INTERVAL  = 8'h04;
   localparam logic [7:0]  A_OFFSET    = 8'h08;
   localparam logic [7:0]  A_INDEX_INIT = 8'h0C;
   localparam logic [7:0]  A_TABLE_SEL = 8'h10;
   localparam logic [7:0]  A_TABLE_DATA = 8'h14;
   localparam logic [7:0]  A_TABLE_AUTO = 8'h18;
   localparam logic [7:0]  A_W0_IDX    = 8'h1C;
   localparam logic [7:0]  A_W0_LEN    = 8'h20;
   localparam logic [7:0]  A_W1_IDX    = 8'h24;
   localparam logic [7:0]  A_W1_LEN    = 8'h28;
   localparam logic [7:0]  A_CYCLES    = 8'h2C;
   localparam logic [7:0]  A_MODULUS   = 8'h30;
   localparam logic [7:0]  A_STATUS    = 8'h34;
   localparam logic [7:0]  A_SLAVE     = 8'h38;
   // field positions and limits
   localparam int          CTRL_RUN_BIT = 0;
   localparam int          STAT_VALID_BIT = 16;
   localparam logic [8:0]  TABLE_LAST  = 9'h100;
   localparam logic [7:0]  SEG_LAST    = 8'hFF;
   localparam logic [31:0] WIDEN_NONE  = 32'hFFFF_FFFF;
   localparam logic [31:0] W0_IDX_MIN  = 32'h0000_0001;
   localparam logic [31:0] W1_IDX_MIN  = 32'h0000_0003;
   localparam logic [31:0] W_IDX_MAX   = 32'h0000_00FF;
   localparam logic [31:0] LEN_MAX     = 32'h7FFF_FFFF;
   localparam logic [15:0] INTERVAL_MIN = 16'h0001;
   localparam logic [15:0] INTERVAL_MAX = 16'h7FFF;
   localparam logic [15:0] INTERVAL_RST = 16'h0100;
   typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_RD1, ST_RD2, ST_DIV} seek_t;
endpackage : cam_pkg

// ---- rtl/cam_table_mem.sv ----
`timescale 1ns/1ps
module cam_table_mem
   import cam_pkg::*;
#(
   parameter int DEPTH = TABLE_DEPTH,
   parameter int WIDTH = DATA_W,
   parameter int AW    = IDX_W
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    a_addr,
   output      logic [WIDTH-1:0] a_q,
   input  wire logic [AW-1:0]    b_addr,
   output      logic [WIDTH-1:0] b_q
);
   logic [WIDTH-1:0] mem [DEPTH];

   if (DEPTH > (1 << AW)) begin : g_chk
      $error("table depth does not fit the address width");
   end

   // write-first on both ports so a read right after a write never sees stale data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
         a_q <= '0;
         b_q <= '0;
      end else begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         a_q <= (we && waddr == a_addr) ? wdata : mem[a_addr];
         b_q <= (we && waddr == b_addr) ? wdata : mem[b_addr];
      end
   end
endmodule : cam_table_mem

// ---- rtl/cam_table_unit.sv ----
// Behaviour
// RULE_01: the table keeps slave positions at indices 0 to 256, entry k meaning master at k*interval+offset.
// RULE_02: each entry is a signed 32-bit value of unit resolution and resets to zero.
// RULE_03: the auto-index write works only after the index counter was set, and each one advances it by one.
// RULE_04: a read of an entry returns the stored slave position; master positions are never stored.
// RULE_05: at most two widened segments exist and they are shared by every cam axis.
// RULE_06: the first widened index takes 1 to 255 or -1 for none, its length 1 to 2147483647, default 0.
// RULE_07: the second widened index takes 3 to 255 or -1 and must lie above the first.
// RULE_08: the second widened segment acts only while the first one is in use.
// RULE_09: the commander should not widen the first, the last or two adjacent segments.
// RULE_10: four readbacks give first index, first length, second index, second length in that order.
// RULE_11: the cycle counter counts up on a positive modulus wrap and down on a negative one.
// RULE_12: the cycle counter is a writable and readable signed 32-bit value, reset to zero.
// RULE_13: software may form absolute position as cycle count times modulus plus axis position.
// RULE_14: the interval takes 1 to 32767, resets to 256 and cannot change while the cam runs.
// RULE_15: the table offset may change while running and shifts the curve at the next sample.
// RULE_16: between table points the slave command is linearly interpolated over the segment length.
`timescale 1ns/1ps
module cam_table_unit
   import cam_pkg::*;
#(
   parameter int SAMPLE_DIV = 1000
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output      logic [31:0]       reg_rdata,
   input  wire logic [31:0]       master_pos,
   output      logic [31:0]       slave_cmd,
   output      logic              slave_strobe
);
   // a sample must leave room for a full seek across the table plus the divide
   if (SAMPLE_DIV < 400 || SAMPLE_DIV > 65535) begin : g_chk
      $error("SAMPLE_DIV out of range");
   end

   typedef struct packed {
      logic               run;
      logic [15:0]        interval;
      logic [31:0]        offset;
      logic [31:0]        modulus;
      logic [8:0]         idx_sel;
      logic [8:0]         idx_cnt;
      logic               idx_valid;
      logic [31:0]        w0_idx;
      logic [31:0]        w0_len;
      logic [31:0]        w1_idx;
      logic [31:0]        w1_len;
      logic [31:0]        cycles;
      logic [31:0]        prev_master;
      logic               prev_ok;
      logic [15:0]        tick_cnt;
      seek_t              st;
      logic [7:0]         seg;
      logic signed [35:0] start;
      logic signed [35:0] rel;
      logic [31:0]        y0;
      logic [31:0]        slave;
      logic               strobe;
      logic [31:0]        rdata;
   } state_t;

   state_t r, n;

   logic               mem_we;
   logic [8:0]         mem_waddr;
   logic [8:0]         mem_a_addr;
   logic [31:0]        mem_a_q;
   logic [31:0]        mem_b_q;
   logic               div_go;
   logic signed [32:0] div_dy;
   logic [31:0]        div_frac;
   logic [31:0]        div_len;
   logic               div_done;
   logic [31:0]        div_res;
   logic               tick;
   logic               wrap_up;
   logic               wrap_dn;
   logic [31:0]        cur_len;
   logic [31:0]        prev_len;
   logic signed [32:0] delta;
   logic signed [32:0] half;
   logic signed [35:0] diff;

   // length of segment k, with widening shared by all axes
   function automatic logic [31:0] seg_len(input state_t s, input logic [7:0] k);
      logic w0_on;
      logic w1_on;
      w0_on = s.w0_idx != WIDEN_NONE && s.w0_len != '0;
      w1_on = w0_on && s.w1_idx != WIDEN_NONE && s.w1_len != '0 && s.w1_idx > s.w0_idx;
      if (w0_on && {24'h00_0000, k} == s.w0_idx) begin
         seg_len = s.w0_len;
      end else if (w1_on && {24'h00_0000, k} == s.w1_idx) begin
         seg_len = s.w1_len;
      end else begin
         seg_len = {16'h0000, s.interval};
      end
   endfunction : seg_len

   always_comb begin
      n = r;
      n.strobe = 1'b0;
      n.rdata = '0;
      mem_we = 1'b0;
      mem_waddr = r.idx_sel;
      mem_a_addr = {1'b0, r.seg};
      div_go = 1'b0;
      div_dy = '0;
      div_frac = '0;
      div_len = '0;
      // RULE_05 RULE_08 shared widening
      cur_len = seg_len(r, r.seg);
      prev_len = seg_len(r, r.seg - 8'h01);
      diff = r.rel - r.start;

      tick = r.tick_cnt == 16'(SAMPLE_DIV - 1);
      n.tick_cnt = tick ? '0 : r.tick_cnt + 16'h0001;

      // RULE_11 wrap detection by jump larger than half the modulus
      delta = $signed({master_pos[31], master_pos}) - $signed({r.prev_master[31], r.prev_master});
      half = $signed({2'b00, r.modulus[31:1]});
      wrap_up = tick && r.run && r.prev_ok && r.modulus != '0 && delta < -half;
      wrap_dn = tick && r.run && r.prev_ok && r.modulus != '0 && delta > half;
      if (wrap_up) begin
         n.cycles = r.cycles + 32'h0000_0001;
      end else if (wrap_dn) begin
         n.cycles = r.cycles - 32'h0000_0001;
      end
      if (tick) begin
         n.prev_master = master_pos;
         n.prev_ok = r.run;
      end

      case (r.st)
         ST_IDLE: begin
            if (tick && r.run) begin
               // RULE_15 offset taken fresh every sample
               n.rel = 36'($signed(master_pos)) - 36'($signed(r.offset));
               n.st = ST_SEEK;
            end
         end
         ST_SEEK: begin
            if (r.rel >= r.start + $signed({4'h0, cur_len}) && r.seg != SEG_LAST) begin
               n.seg = r.seg + 8'h01;
               n.start = r.start + $signed({4'h0, cur_len});
            end else if (r.rel < r.start && r.seg != 8'h00) begin
               n.seg = r.seg - 8'h01;
               n.start = r.start - $signed({4'h0, prev_len});
            end else begin
               n.st = ST_RD1;
            end
         end
         ST_RD1: begin
            n.y0 = mem_a_q;
            mem_a_addr = {1'b0, r.seg} + 9'h001;
            n.st = ST_RD2;
         end
         ST_RD2: begin
            // RULE_16 interpolate, clamped beyond the ends of the table
            div_go = 1'b1;
            div_dy = $signed({mem_a_q[31], mem_a_q}) - $signed({r.y0[31], r.y0});
            div_len = cur_len;
            if (diff < 0) begin
               div_frac = '0;
            end else if (diff >= $signed({4'h0, cur_len})) begin
               div_frac = cur_len;
            end else begin
               div_frac = diff[31:0];
            end
            n.st = ST_DIV;
         end
         ST_DIV: begin
            if (div_done) begin
               n.slave = div_res;
               n.strobe = 1'b1;
               n.st = ST_IDLE;
            end
         end
         default: n.st = ST_IDLE;
      endcase

      if (reg_wr) begin
         case (reg_addr)
            A_CTRL: begin
               n.run = reg_wdata[CTRL_RUN_BIT];
               if (reg_wdata[CTRL_RUN_BIT] && !r.run) begin
                  n.seg = '0;
                  n.start = '0;
                  n.prev_ok = 1'b0;
               end
            end
            A_INTERVAL: begin
               // RULE_14 frozen while running
               if (!r.run && reg_wdata[15:0] >= INTERVAL_MIN &&
                   reg_wdata <= {16'h0000, INTERVAL_MAX}) begin
                  n.interval = reg_wdata[15:0];
               end
            end
            A_OFFSET:  n.offset = reg_wdata;
            A_MODULUS: n.modulus = reg_wdata;
            A_INDEX_INIT: begin
               if (reg_wdata <= {23'h00_0000, TABLE_LAST}) begin
                  n.idx_cnt = reg_wdata[8:0];
                  n.idx_valid = 1'b1;
               end
            end
            A_TABLE_SEL: begin
               if (reg_wdata <= {23'h00_0000, TABLE_LAST}) begin
                  n.idx_sel = reg_wdata[8:0];
               end
            end
            // RULE_01 RULE_02 explicit entry write
            A_TABLE_DATA: mem_we = 1'b1;
            A_TABLE_AUTO: begin
               // RULE_03 auto index needs an initialised counter
               if (r.idx_valid && r.idx_cnt <= TABLE_LAST) begin
                  mem_we = 1'b1;
                  mem_waddr = r.idx_cnt;
                  n.idx_cnt = r.idx_cnt + 9'h001;
               end
            end
            A_W0_IDX: begin
               // RULE_06 first widening index
               if (reg_wdata == WIDEN_NONE ||
                   (reg_wdata >= W0_IDX_MIN && reg_wdata <= W_IDX_MAX)) begin
                  n.w0_idx = reg_wdata;
               end
            end
            A_W0_LEN: begin
               if (reg_wdata != '0 && reg_wdata <= LEN_MAX) begin
                  n.w0_len = reg_wdata;
               end
            end
            A_W1_IDX: begin
               // RULE_07 second index above the first
               if (reg_wdata == WIDEN_NONE ||
                   (reg_wdata >= W1_IDX_MIN && reg_wdata <= W_IDX_MAX &&
                    r.w0_idx != WIDEN_NONE && reg_wdata > r.w0_idx)) begin
                  n.w1_idx = reg_wdata;
               end
            end
            A_W1_LEN: begin
               if (reg_wdata != '0 && reg_wdata <= LEN_MAX) begin
                  n.w1_len = reg_wdata;
               end
            end
            // RULE_12 software load beats a same-cycle wrap
            A_CYCLES: n.cycles = reg_wdata;
            default: ;
         endcase
      end

      if (reg_rd) begin
         case (reg_addr)
            A_CTRL:       n.rdata = {31'h0000_0000, r.run};
            A_INTERVAL:   n.rdata = {16'h0000, r.interval};
            A_OFFSET:     n.rdata = r.offset;
            A_MODULUS:    n.rdata = r.modulus;
            A_INDEX_INIT: n.rdata = {23'h00_0000, r.idx_cnt};
            A_TABLE_SEL:  n.rdata = {23'h00_0000, r.idx_sel};
            // RULE_04 stored slave entry
            A_TABLE_DATA: n.rdata = mem_b_q;
            // RULE_10 widening readbacks in order
            A_W0_IDX:     n.rdata = r.w0_idx;
            A_W0_LEN:     n.rdata = r.w0_len;
            A_W1_IDX:     n.rdata = r.w1_idx;
            A_W1_LEN:     n.rdata = r.w1_len;
            A_CYCLES:     n.rdata = r.cycles;
            A_STATUS: begin
               n.rdata = {23'h00_0000, r.idx_cnt};
               n.rdata[STAT_VALID_BIT] = r.idx_valid;
            end
            A_SLAVE:      n.rdata = r.slave;
            default:      n.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
         r.interval <= INTERVAL_RST;
         r.w0_idx <= WIDEN_NONE;
         r.w1_idx <= WIDEN_NONE;
         r.st <= ST_IDLE;
      end else begin
         r <= n;
      end
   end

   cam_table_mem u_mem (
      .clk     (clk),
      .sys_rst (sys_rst),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (reg_wdata),
      .a_addr  (mem_a_addr),
      .a_q     (mem_a_q),
      .b_addr  (n.idx_sel),
      .b_q     (mem_b_q)
   );

   cam_interp u_interp (
      .clk     (clk),
      .sys_rst (sys_rst),
      .go      (div_go),
      .y0      (r.y0),
      .dy      (div_dy),
      .frac    (div_frac),
      .len     (div_len),
      .done    (div_done),
      .result  (div_res)
   );

   assign reg_rdata = r.rdata;
   assign slave_cmd = r.slave;
   assign slave_strobe = r.strobe;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_entry_addr: assert property (mem_we |-> mem_waddr <= TABLE_LAST) // RULE_01
      else $error("table write outside 0..256");
   chk_auto_step: assert property ( // RULE_03
      reg_wr && reg_addr == A_TABLE_AUTO && r.idx_valid && r.idx_cnt <= TABLE_LAST
      |=> r.idx_cnt == $past(r.idx_cnt) + 9'h001)
      else $error("auto index did not advance by one");
   chk_auto_block: assert property ( // RULE_03
      reg_wr && reg_addr == A_TABLE_AUTO && !r.idx_valid |-> !mem_we)
      else $error("auto write without initialised index");
   chk_entry_read: assert property ( // RULE_04
      reg_wr && reg_addr == A_TABLE_DATA ##1 reg_rd && reg_addr == A_TABLE_DATA
      && $stable(r.idx_sel) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("entry readback differs from stored value");
   chk_w0_range: assert property ( // RULE_06
      r.w0_idx == WIDEN_NONE || (r.w0_idx >= W0_IDX_MIN && r.w0_idx <= W_IDX_MAX))
      else $error("first widened index out of range");
   chk_w1_order: assert property ( // RULE_07
      reg_wr && reg_addr == A_W1_IDX && reg_wdata != WIDEN_NONE && reg_wdata <= r.w0_idx
      |=> $stable(r.w1_idx))
      else $error("second widened index accepted below first");
   chk_w1_alone: assert property ( // RULE_08
      r.w0_idx == WIDEN_NONE |-> cur_len == {16'h0000, r.interval})
      else $error("widening applied without first segment");
   chk_interval_hold: assert property (r.run |=> $stable(r.interval)) // RULE_14
      else $error("interval changed while running");
   chk_cycle_up: assert property ( // RULE_11
      wrap_up && !(reg_wr && reg_addr == A_CYCLES) |=> r.cycles == $past(r.cycles) + 1)
      else $error("positive wrap not counted");
   chk_cycle_load: assert property ( // RULE_12
      reg_wr && reg_addr == A_CYCLES |=> reg_rd && reg_addr == A_CYCLES
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("cycle counter load lost");
   chk_interp_done: assert property ( // RULE_16
      r.st == ST_RD2 |-> ##[60:80] slave_strobe)
      else $error("interpolated point not delivered");

   cov_auto_load: cover property (reg_wr && reg_addr == A_TABLE_AUTO && mem_we);
   cov_wrap_up:   cover property (wrap_up);
   cov_wrap_dn:   cover property (wrap_dn);
   cov_point:     cover property (slave_strobe);
endmodule : cam_table_unit

// ---- tb/cmd_interp_model.sv ----
`timescale 1ns/1ps
module cmd_interp_model
   import cam_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [31:0]       reg_rdata,
   output      logic [ADDR_W-1:0] reg_addr,
   output      logic [31:0]       reg_wdata,
   output      logic              reg_wr,
   output      logic              reg_rd
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      // idle data is inverted so a stale word is never mistaken for a new one
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // write then read back with the strobes back to back, no idle cycle between
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      reg_wdata <= ~d;
      @(posedge clk);
      reg_rd    <= 1'b0;
      #1 q = reg_rdata;
   endtask : wr_rd

   // absolute position as cycle count times modulus plus position
   task automatic abs_pos(input logic [31:0] pos, output logic [31:0] p);
      logic [31:0] c;
      logic [31:0] m;
      rd(A_CYCLES, c);
      rd(A_MODULUS, m);
      p = c * m + pos;
   endtask : abs_pos
endmodule : cmd_interp_model

// ---- tb/electronic_cam_table_unit_tb_top.sv ----
`timescale 1ns/1ps
module electronic_cam_table_unit_tb_top
   import cam_pkg::*;
();
   logic              clk;
   logic              sys_rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [31:0]       reg_rdata;
   logic [31:0]       master_pos;
   logic [31:0]       slave_cmd;
   logic              slave_strobe;
   logic [31:0]       last_cmd;
   logic [31:0]       rdv;
   int                miscompares = 0;
   int                tests_run   = 0;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // short sample period keeps the run small
   cam_table_unit #(.SAMPLE_DIV(400)) dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_pos(master_pos),
      .slave_cmd(slave_cmd), .slave_strobe(slave_strobe));

   cmd_interp_model host (
      .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));

   task automatic conclude();
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      host.rd(a, d);
      cmp(d, exp, $sformatf("read of %h", a));
   endtask : chk

   // the first strobe after a change may belong to a sample taken before it
   task automatic wait_point(input int n);
      int i;
      for (int k = 0; k < n; k++) begin
         i = 0;
         while (slave_strobe !== 1'b1 && i < 1000) begin
            @(posedge clk);
            #1;
            i++;
         end
         if (i == 1000) begin
            miscompares++;
            $display("unexpected at %0t: no slave strobe", $time);
            conclude();
         end
         last_cmd = slave_cmd;
         @(posedge clk);
         #1;
      end
   endtask : wait_point

   task automatic end_test(input string name);
      $display("test %s finished", name);
   endtask : end_test

   initial begin
      sys_rst    = 1'b1;
      master_pos = 32'h0000_0000;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      chk(A_INTERVAL, 32'h0000_0100);
      chk(A_W0_IDX, 32'hFFFF_FFFF);
      chk(A_W0_LEN, 32'h0000_0000);
      chk(A_W1_IDX, 32'hFFFF_FFFF);
      chk(A_W1_LEN, 32'h0000_0000);
      chk(A_CYCLES, 32'h0000_0000);
      chk(A_TABLE_DATA, 32'h0000_0000);
      host.wr(8'h3C, 32'h1234_5678);
      chk(8'h3C, 32'h0000_0000);
      end_test("reset");
      host.wr(A_TABLE_SEL, 32'h0000_0100);
      host.wr(A_TABLE_DATA, 32'h7FFF_FFFF);
      host.wr(A_TABLE_SEL, 32'h0000_0101);
      chk(A_TABLE_DATA, 32'h7FFF_FFFF);
      host.wr(A_TABLE_SEL, 32'h0000_0000);
      host.wr_rd(A_TABLE_DATA, 32'h8000_0000, rdv);
      cmp(rdv, 32'h8000_0000, "entry write then read");
      host.wr(A_TABLE_SEL, 32'h0000_0100);
      chk(A_TABLE_DATA, 32'h7FFF_FFFF);
      end_test("table");
      host.wr(A_TABLE_AUTO, 32'h0000_0001);
      chk(A_STATUS, 32'h0000_0000);
      host.wr(A_INDEX_INIT, 32'h0000_0000);
      host.wr(A_TABLE_AUTO, 32'h0000_0000);
      host.wr(A_TABLE_AUTO, 32'h0000_03E8);
      chk(A_STATUS, 32'h0001_0002);
      host.wr(A_TABLE_SEL, 32'h0000_0001);
      chk(A_TABLE_DATA, 32'h0000_03E8);
      end_test("auto");
      host.wr(A_W1_IDX, 32'h0000_007C);
      chk(A_W1_IDX, 32'hFFFF_FFFF);
      host.wr(A_W0_IDX, 32'h0000_0000);
      chk(A_W0_IDX, 32'hFFFF_FFFF);
      host.wr(A_W0_IDX, 32'h0000_0029);
      host.wr(A_W1_IDX, 32'h0000_0029);
      chk(A_W1_IDX, 32'hFFFF_FFFF);
      host.wr(A_W1_IDX, 32'h0000_007C);
      host.wr(A_W0_LEN, 32'h0000_02B0);
      host.wr(A_W1_LEN, 32'h8000_0000);
      host.wr(A_W1_LEN, 32'h7FFF_FFFF);
      chk(A_W0_IDX, 32'h0000_0029);
      chk(A_W0_LEN, 32'h0000_02B0);
      chk(A_W1_IDX, 32'h0000_007C);
      chk(A_W1_LEN, 32'h7FFF_FFFF);
      end_test("widen");
      host.wr_rd(A_CYCLES, 32'h8000_0000, rdv);
      cmp(rdv, 32'h8000_0000, "cycle load then read");
      host.wr(A_CYCLES, 32'h0000_0005);
      host.wr(A_INTERVAL, 32'h0000_0000);
      host.wr(A_INTERVAL, 32'h0000_7FFF);
      chk(A_INTERVAL, 32'h0000_7FFF);
      host.wr(A_INTERVAL, 32'h0000_0064);
      host.wr(A_MODULUS, 32'h0000_03E8);
      master_pos <= 32'h0000_0032;
      host.wr(A_CTRL, 32'h0000_0001);
      host.wr(A_INTERVAL, 32'h0000_0005);
      chk(A_INTERVAL, 32'h0000_0064);
      wait_point(2);
      cmp(last_cmd, 32'h0000_01F4, "slave point");
      host.wr(A_OFFSET, 32'h0000_0019);
      wait_point(2);
      cmp(last_cmd, 32'h0000_00FA, "slave point");
      end_test("interpolate");
      // climb in two moves so that neither jump exceeds half the modulus
      master_pos <= 32'h0000_0190;
      wait_point(2);
      master_pos <= 32'h0000_0384;
      wait_point(2);
      master_pos <= 32'h0000_0064;
      wait_point(2);
      chk(A_CYCLES, 32'h0000_0006);
      chk(A_SLAVE, 32'h0000_02EE);
      master_pos <= 32'h0000_0384;
      wait_point(2);
      chk(A_CYCLES, 32'h0000_0005);
      host.abs_pos(master_pos, rdv);
      cmp(rdv, 32'h0000_170C, "absolute position");
      end_test("cycles");
      // negative offset puts the sample inside widened segment 41
      host.wr(A_TABLE_SEL, 32'h0000_002A);
      host.wr(A_TABLE_DATA, 32'h0000_02B0);
      host.wr(A_OFFSET, 32'hFFFF_F228);
      wait_point(2);
      cmp(last_cmd, 32'h0000_0158, "widened point");
      end_test("widened");
      conclude();
   end
endmodule : electronic_cam_table_unit_tb_top
